// File: verilog/psp_port.sv
`timescale 1ns/1ps
// Overview of operation
// - Two protocols: legacy single-target and shared bus with eight targets.
// - Five address bits in shared-bus frames, six in legacy frames.
// - Register zero reads a 24-bit identifier; writing it issues commands.
// - Register zero write: pointer 4:0 (shared bus), soft reset 5, strobes.
// - Protocol fixed at first activity after hard reset, until the next hard reset.
// - Select rising edge seen first locks legacy protocol.
// - Shift clock rising edge seen first locks shared-bus protocol.
// - Legacy frame is read/write bit, six address bits, 24 data bits.
// - Writes need three wires; reads also need the serial output.
// - First rising edge after select samples input: low write, high read.
// - Address bits MSB first, shifted in on rising edges 2 to 7.
// - Write data MSB first, shifted in on rising edges 8 to 31.
// - Legacy write data commits on the 32nd rising edge.
// - Input high at the first edge makes the frame a read.
// - Legacy read drives 24 bits MSB first on rising edges 8 to 31.
// - Lock returns on edge 32 and holds until first read bit.
// - Shared-bus frames carry a three-bit chip address.
// - Shared-bus frames shift read data out while write data shifts in.
// - Shared-bus frame: 24 data, 5 address, 3 chip bits, MSB first.
// - Shared-bus frame commits on the select rising edge.
// - Shared-bus read returns the register named by the pointer.
module psp_port
    import psp_pkg::*;
#(
    parameter int REG_COUNT = 32,
    parameter logic [DATA_W-1:0] CHIP_ID = 24'h5A0C31 // Arbitrary value
) (
    // Core clock and hard reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Serial link
    input wire logic i_shift_clk,
    input wire logic i_port_select_strobe,
    input wire logic i_serial_input_line,
    output logic o_lock_or_serial_output,
    // Core side
    input wire logic i_lock_indicator,
    input wire logic [CHIP_ADDR_W-1:0] i_chip_address,
    output logic [REG_COUNT-1:0][DATA_W-1:0] o_config,
    output logic o_soft_reset,
    output logic [STRB_W-1:0] o_strobes,
    output logic o_legacy_mode,
    output logic o_open_mode
);

    typedef struct packed {
        psp_mode_t mode;
        logic [REG_COUNT-1:0][DATA_W-1:0] regs;
        logic [PTR_W-1:0] ptr;
        logic sen_prev;
        logic act_prev;
        logic done_prev;
        logic srst;
        logic [STRB_W-1:0] strobes;
    } psp_core_t;

    localparam psp_core_t CORE_RESET = '{mode: MODE_LISTEN, default: '0};

    psp_core_t c_q;
    psp_core_t c_d;
    psp_link_t l_q;
    psp_link_t l_d;

    logic sen_s;
    logic act_s;
    logic done_s;
    logic lock_s;
    logic [CHIP_ADDR_W-1:0] chip_s;
    logic sen_rise;
    logic act_chg;
    logic done_evt;
    psp_leg_frame_t leg_fr;
    psp_open_frame_t open_fr;
    psp_cmd_t leg_cmd;
    logic [LEG_ADDR_W-1:0] leg_addr;
    logic [DATA_W-1:0] leg_data;
    logic [PTR_W-1:0] open_ptr;

    // Reads the identifier at zero; unmapped addresses read zero
    function automatic logic [DATA_W-1:0] rd_word(
        input logic [REG_COUNT-1:0][DATA_W-1:0] regs,
        input logic [LEG_ADDR_W-1:0] addr
    );
        logic [DATA_W-1:0] w;
        w = '0;
        if (addr == REG0_OFFSET) begin
            w = CHIP_ID;
        end
        for (int i = 1; i < REG_COUNT; i++) begin
            if (addr == LEG_ADDR_W'(i)) begin
                w = regs[i];
            end
        end
        return w;
    endfunction

    // Select, link events, lock and strap enter the core clock domain
    psp_sync #(
        .WIDTH(4 + CHIP_ADDR_W)
    ) u_sync (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_async({i_port_select_strobe, l_q.act_tgl, l_q.done_tgl,
                  i_lock_indicator, i_chip_address}),
        .o_sync({sen_s, act_s, done_s, lock_s, chip_s})
    );

    assign sen_rise = sen_s & ~c_q.sen_prev;
    assign act_chg = act_s ^ c_q.act_prev;
    assign done_evt = done_s ^ c_q.done_prev;

    // Shift register is quiet between frames, so the core reads it directly
    assign leg_fr = psp_leg_frame_t'(l_q.shift[FRAME_W-1:1]);
    assign open_fr = psp_open_frame_t'(l_q.shift);
    assign leg_cmd = psp_cmd_t'(leg_fr.data);
    assign leg_addr = leg_fr.addr;
    assign leg_data = leg_fr.data;
    assign open_ptr = open_fr.data[PTR_W-1:0];

    always_comb begin
        logic wr_en;
        logic [LEG_ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        psp_cmd_t cmd;
        wr_en = 1'b0;
        wr_addr = '0;
        wr_data = '0;
        cmd = '0;
        c_d = c_q;
        c_d.sen_prev = sen_s;
        c_d.act_prev = act_s;
        c_d.done_prev = done_s;
        c_d.srst = 1'b0;
        c_d.strobes = '0;
        case (c_q.mode)
            MODE_LISTEN: begin
                // Select wins a tie: its edge is the only one that can beat
                if (sen_rise) begin
                    c_d.mode = MODE_LEGACY;
                end else if (act_chg) begin
                    c_d.mode = MODE_OPEN;
                end
            end
            MODE_LEGACY: begin
                if (done_evt && leg_fr.rw != RW_READ) begin
                    wr_en = 1'b1;
                    wr_addr = leg_fr.addr;
                    wr_data = leg_fr.data;
                end
            end
            MODE_OPEN: begin
                if (sen_rise && open_fr.chip == chip_s) begin
                    wr_en = 1'b1;
                    wr_addr = {1'b0, open_fr.addr};
                    wr_data = open_fr.data;
                end
            end
            default: begin
                c_d.mode = MODE_LISTEN;
            end
        endcase
        // Mode never leaves legacy or shared bus short of a hard reset
        cmd = psp_cmd_t'(wr_data);
        if (wr_en && wr_addr == REG0_OFFSET) begin
            c_d.srst = cmd.srst;
            c_d.strobes = cmd.strobes;
            if (c_q.mode == MODE_OPEN) begin
                c_d.ptr = cmd.ptr;
            end
            if (cmd.srst) begin
                for (int i = 0; i < REG_COUNT; i++) begin
                    c_d.regs[i] = REG_RESET;
                end
            end
        end else if (wr_en) begin
            for (int i = 1; i < REG_COUNT; i++) begin
                if (wr_addr == LEG_ADDR_W'(i)) begin
                    c_d.regs[i] = wr_data;
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            c_q <= CORE_RESET;
        end else begin
            c_q <= c_d;
        end
    end

    // Link side: select and data are timed to the shift clock itself
    always_comb begin
        logic leg;
        logic [DATA_W-1:0] w;
        leg = l_q.legacy_frame;
        w = '0;
        l_d = l_q;
        l_d.act_tgl = ~l_q.act_tgl;
        l_d.cnt = l_q.cnt + CNT_STEP;
        l_d.shift = {l_q.shift[FRAME_W-2:0], i_serial_input_line};
        l_d.out = l_q.rdsh[DATA_W-1];
        l_d.rdsh = {l_q.rdsh[DATA_W-2:0], 1'b0};
        if (l_q.cnt == CNT_FIRST) begin
            // Select high at edge 1 marks a legacy frame unless shared bus is locked
            leg = i_port_select_strobe & ~c_q.mode[OPEN_BIT];
            l_d.legacy_frame = leg;
        end
        if (l_q.cnt == CNT_FIRST && !leg) begin
            w = rd_word(c_q.regs, {1'b0, c_q.ptr});
            l_d.out = w[DATA_W-1];
            l_d.rdsh = {w[DATA_W-2:0], 1'b0};
            l_d.sel = 1'b1;
        end
        if (l_q.cnt == CNT_LEG_DATA && leg
            && l_q.shift[LEG_ADDR_W] == RW_READ) begin
            w = rd_word(c_q.regs, l_q.shift[LEG_ADDR_W-1:0]);
            l_d.out = w[DATA_W-1];
            l_d.rdsh = {w[DATA_W-2:0], 1'b0};
            l_d.sel = 1'b1;
        end
        if (l_q.cnt == CNT_LAST) begin
            l_d.sel = 1'b0;
            l_d.done_tgl = ~l_q.done_tgl;
        end
    end

    // Counter wraps after 32 edges; a short frame misaligns the next one
    always_ff @(posedge i_shift_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // Pin mux of two flops: lock stays live until the first read bit
    assign o_lock_or_serial_output = l_q.sel ? l_q.out : lock_s;
    assign o_config = c_q.regs;
    assign o_soft_reset = c_q.srst;
    assign o_strobes = c_q.strobes;
    assign o_legacy_mode = c_q.mode[LEGACY_BIT];
    assign o_open_mode = c_q.mode[OPEN_BIT];

    a_mode_sticky: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        c_q.mode != MODE_LISTEN |=> c_q.mode == $past(c_q.mode))
        else $error("Protocol changed after it was fixed");

    a_legacy_first: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        c_q.mode == MODE_LISTEN && sen_rise |=> c_q.mode == MODE_LEGACY)
        else $error("Select edge did not lock legacy protocol");

    a_open_first: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        c_q.mode == MODE_LISTEN && !sen_rise && act_chg
        |=> c_q.mode == MODE_OPEN)
        else $error("Clock edge did not lock shared-bus protocol");

    a_legacy_commit: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        c_q.mode == MODE_LEGACY && done_evt && leg_fr.rw != RW_READ
        && leg_addr != REG0_OFFSET && int'(leg_addr) < REG_COUNT
        |=> c_q.regs[$past(leg_addr)] == $past(leg_data))
        else $error("Legacy write data not committed");

    a_soft_reset_pulse: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        c_q.mode == MODE_LEGACY && done_evt && leg_fr.rw != RW_READ
        && leg_addr == REG0_OFFSET && leg_cmd.srst
        |=> c_q.srst && c_q.regs == '0 ##1 !c_q.srst)
        else $error("Soft reset not one cycle pulse");

    a_pointer_load: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        c_q.mode == MODE_OPEN && sen_rise && open_fr.chip == chip_s
        && open_fr.addr == '0
        |=> c_q.ptr == $past(open_ptr))
        else $error("Read pointer not loaded");

    a_chip_filter: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        c_q.mode == MODE_OPEN && sen_rise && open_fr.chip != chip_s
        |=> $stable(c_q.regs) && $stable(c_q.ptr) && !c_q.srst)
        else $error("Frame for another chip was applied");

    a_read_window: assert property (
        @(posedge i_shift_clk) disable iff (!i_arst_n)
        l_q.legacy_frame && l_q.cnt == CNT_LEG_DATA
        && l_q.shift[LEG_ADDR_W] == RW_READ
        |=> l_q.sel [*8])
        else $error("Read data not driven from edge 8");

    a_lock_hold: assert property (
        @(posedge i_shift_clk) disable iff (!i_arst_n)
        l_q.legacy_frame && l_q.cnt <= CNT_LEG_DATA |-> !l_q.sel)
        else $error("Lock replaced before first read bit");

    a_lock_return: assert property (
        @(posedge i_shift_clk) disable iff (!i_arst_n)
        l_q.cnt == CNT_LAST |=> !l_q.sel && l_q.cnt == CNT_FIRST)
        else $error("Lock not restored at edge 32");

    a_open_drive: assert property (
        @(posedge i_shift_clk) disable iff (!i_arst_n)
        l_q.cnt == CNT_FIRST && !i_port_select_strobe
        |=> l_q.sel && !l_q.legacy_frame)
        else $error("Shared-bus frame did not drive read data");

endmodule

// File: verilog/psp_pkg.sv
package psp_pkg;

    // Widths of the serial frames
    localparam int DATA_W = 24;
    localparam int LEG_ADDR_W = 6;
    localparam int OPEN_ADDR_W = 5;
    localparam int CHIP_ADDR_W = 3;
    localparam int FRAME_W = 32;
    localparam int CNT_W = 5;
    localparam int STRB_W = 18;
    localparam int PTR_W = 5;

    // Edge counter values seen just before edge 1, 8 and 32 of a frame
    localparam logic [CNT_W-1:0] CNT_FIRST = 5'h00;
    localparam logic [CNT_W-1:0] CNT_LEG_DATA = 5'h07;
    localparam logic [CNT_W-1:0] CNT_LAST = 5'h1F;
    localparam logic [CNT_W-1:0] CNT_STEP = 5'h01;

    // Register map
    localparam logic [LEG_ADDR_W-1:0] REG0_OFFSET = 6'h00;
    localparam logic [DATA_W-1:0] REG_RESET = 24'h000000;
    localparam logic RW_READ = 1'b1;

    // Positions of the one-hot protocol bits
    localparam int LEGACY_BIT = 1;
    localparam int OPEN_BIT = 2;

    typedef enum logic [2:0] {
        MODE_LISTEN = 3'b001,
        MODE_LEGACY = 3'b010,
        MODE_OPEN = 3'b100
    } psp_mode_t;

    // Legacy frame: 1 + 6 + 24 bits, first bit received is the MSB
    typedef struct packed {
        logic rw;
        logic [LEG_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } psp_leg_frame_t;

    // Shared-bus frame: data, register address, chip address
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [OPEN_ADDR_W-1:0] addr;
        logic [CHIP_ADDR_W-1:0] chip;
    } psp_open_frame_t;

    // Write layout of register zero
    typedef struct packed {
        logic [STRB_W-1:0] strobes;
        logic srst;
        logic [PTR_W-1:0] ptr;
    } psp_cmd_t;

    // Link side state, clocked by the shift clock
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic [FRAME_W-1:0] shift;
        logic [DATA_W-1:0] rdsh;
        logic out;
        logic sel;
        logic legacy_frame;
        logic act_tgl;
        logic done_tgl;
    } psp_link_t;

endpackage

// File: verilog/psp_sync.sv
`timescale 1ns/1ps
module psp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Levels in and out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } psp_sync_st_t;

    psp_sync_st_t s_q;
    psp_sync_st_t s_d;

    // First stage feeds only the second stage
    always_comb begin
        s_d.meta = i_async;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.stable;

endmodule

// File: tb/psp_host.sv
`timescale 1ns/1ps
module psp_host (
    // Link pins driven by the host
    output logic o_shift_clk,
    output logic o_select,
    output logic o_sdi,
    // Shared lock or data pin
    input wire logic i_pin
);
    initial begin
        o_shift_clk = 1'b0;
        o_select = 1'b0;
        o_sdi = 1'b0;
    end

    // Clock runs only inside frames; data changes on falling edges
    task automatic shift32(input logic [31:0] bits, output logic [31:0] seen);
        for (int i = 31; i >= 0; i--) begin
            o_sdi = bits[i];
            #3 o_shift_clk = 1'b1;
            #3 o_shift_clk = 1'b0;
            seen[i] = i_pin;
        end
    endtask

    task automatic leg_frame(input logic rw, input logic [5:0] addr,
        input logic [23:0] data, output logic [23:0] rdata);
        logic [31:0] seen;
        o_sdi = rw;
        o_select = 1'b1;
        #12;
        shift32({rw, addr, data, 1'b0}, seen);
        #10 o_select = 1'b0;
        // Released line shows the inverse, never a stale bit
        o_sdi = ~o_sdi;
        #40;
        rdata = seen[24:1];
    endtask

    task automatic open_frame(input logic [23:0] data, input logic [4:0] addr,
        input logic [2:0] chip, output logic [23:0] rdata);
        logic [31:0] seen;
        shift32({data, addr, chip}, seen);
        #10 o_select = 1'b1;
        #16 o_select = 1'b0;
        o_sdi = ~o_sdi;
        #20;
        rdata = seen[31:8];
    endtask
endmodule

// File: tb/tb_psp_port.sv
`timescale 1ns/1ps
module tb_psp_port;
    import psp_pkg::*;

    typedef struct packed {
        logic [LEG_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] exp;
    } psp_row_t;

    localparam int N_ROWS = 4;
    localparam psp_row_t ROWS [N_ROWS] = '{
        '{6'h01, 24'hA5F00F, 24'hA5F00F},
        '{6'h1F, 24'hFFFFFF, 24'hFFFFFF},
        '{6'h02, 24'h800001, 24'h800001},
        '{6'h20, 24'h123456, 24'h000000}
    };
    // Arbitrary identifier value
    localparam logic [DATA_W-1:0] ID = 24'h3C9E71;

    logic i_clk = 1'b0;
    // Starts high so the first reset is a real falling edge for the link
    logic i_arst_n = 1'b1;
    logic lock = 1'b0;
    logic [CHIP_ADDR_W-1:0] chip = 3'h5;
    wire logic sck;
    wire logic sel;
    wire logic serial_input_line;
    wire logic pin;
    logic [31:0][DATA_W-1:0] cfg;
    logic srst;
    logic [STRB_W-1:0] strb;
    logic legacy;
    logic open_m;
    logic seen_srst;
    logic [STRB_W-1:0] last_strb;
    logic [DATA_W-1:0] rd;
    int fail_count = 0;
    int n_compared = 0;

    always #2 i_clk = ~i_clk;

    psp_port #(.REG_COUNT(32), .CHIP_ID(ID)) dut (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_shift_clk(sck),
        .i_port_select_strobe(sel),
        .i_serial_input_line(serial_input_line),
        .o_lock_or_serial_output(pin),
        .i_lock_indicator(lock),
        .i_chip_address(chip),
        .o_config(cfg),
        .o_soft_reset(srst),
        .o_strobes(strb),
        .o_legacy_mode(legacy),
        .o_open_mode(open_m)
    );

    psp_host host_model (
        .o_shift_clk(sck),
        .o_select(sel),
        .o_sdi(serial_input_line),
        .i_pin(pin)
    );

    // Pulses last one core cycle, so hold them for later checks
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            seen_srst <= 1'b0;
            last_strb <= '0;
        end else begin
            if (srst === 1'b1) seen_srst <= 1'b1;
            if (strb !== '0) last_strb <= strb;
        end
    end

    task automatic check(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic hard_reset();
        @(negedge i_clk) i_arst_n = 1'b0;
        repeat (8) @(negedge i_clk);
        check("pin_in_reset", 32'h0, {31'h0, pin});
        check("mode_in_reset", 32'h0, {30'h0, legacy, open_m});
        check("cfg_reset", 32'h0, {8'h0, cfg[1]});
        i_arst_n = 1'b1;
        repeat (3) @(negedge i_clk);
    endtask

    initial begin
        #40000;
        fail_count++;
        give_verdict();
    end

    initial begin
        hard_reset();
        lock = 1'b1;
        repeat (4) @(negedge i_clk);
        check("lock_idle", 32'h1, {31'h0, pin});
        host_model.leg_frame(RW_READ, REG0_OFFSET, 24'h0, rd);
        check("leg_id", {8'h0, ID}, {8'h0, rd});
        check("leg_mode", 32'h2, {30'h0, legacy, open_m});
        for (int i = 0; i < N_ROWS; i++) begin
            @(negedge i_clk) lock = i[0];
            host_model.leg_frame(1'b0, ROWS[i].addr,
                ROWS[i].data, rd);
            if (ROWS[i].addr < 6'h20) begin
                check("leg_cfg", {8'h0, ROWS[i].data},
                    {8'h0, cfg[ROWS[i].addr[4:0]]});
            end
            host_model.leg_frame(RW_READ, ROWS[i].addr, 24'h0, rd);
            check("leg_read", {8'h0, ROWS[i].exp}, {8'h0, rd});
            check("leg_lock_back", {31'h0, lock}, {31'h0, pin});
        end
        // Six-bit address must not alias onto register zero
        check("leg_no_alias", 32'h0, {13'h0, seen_srst, last_strb});
        host_model.leg_frame(1'b0, REG0_OFFSET, 24'hABCDE0, rd);
        check("leg_srst", 32'h1, {31'h0, seen_srst});
        check("leg_strobes", 32'h2AF37, {14'h0, last_strb});
        check("leg_cleared", 32'h0, {8'h0, cfg[1]});
        // Second hard reset lets the other protocol be chosen
        hard_reset();
        host_model.open_frame(24'h00CAFE, 5'h03, 3'h5, rd);
        check("open_id", {8'h0, ID}, {8'h0, rd});
        check("open_mode", 32'h1, {30'h0, legacy, open_m});
        check("open_cfg", 32'h00CAFE, {8'h0, cfg[3]});
        host_model.open_frame(24'h111111, 5'h04, 3'h2, rd);
        check("open_refused", 32'h0, {8'h0, cfg[4]});
        host_model.open_frame(24'hAAF343, 5'h00, 3'h5, rd);
        check("open_strobes", 32'h2ABCD, {14'h0, last_strb});
        host_model.open_frame(24'hAAF343, 5'h00, 3'h5, rd);
        check("open_read", 32'h00CAFE, {8'h0, rd});
        check("open_srst_idle", 32'h0, {31'h0, seen_srst});
        host_model.open_frame(24'h000023, 5'h00, 3'h5, rd);
        check("open_srst", 32'h1, {31'h0, seen_srst});
        check("open_clear", 32'h0, {8'h0, cfg[3]});
        check("open_still", 32'h1, {30'h0, legacy, open_m});
        give_verdict();
    end
endmodule
